// *** teq_qualifier.sv ***
`timescale 1ns/1ps
`default_nettype none
module teq_qualifier #(
    parameter int UNIT_CYCLES = teq_pkg::UNIT_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [7:0]  reg_wdata_i,
    output logic      [7:0]  reg_rdata_o,
    input  wire logic        poll_tick_i,
    input  wire logic        standby_i,
    input  wire logic [2:0]  touch_det_i,
    input  wire logic [2:0]  noise_i,
    input  wire logic [23:0] delta_i,
    input  wire logic [23:0] active_thr_i,
    input  wire logic [23:0] standby_thr_i,
    input  wire logic [2:0]  irq_enable_i,
    input  wire logic [2:0]  release_irq_enable_i,
    input  wire logic [3:0]  hold_time_code_i,
    input  wire logic [3:0]  repeat_rate_code_i,
    input  wire logic        int_clear_i,
    output logic      [2:0]  touch_status_o,
    output logic             many_touch_flag_o,
    output logic             pattern_event_flag_o,
    output logic             pattern_block_o,
    output logic             int_status_o,
    output logic             alert_n_o
);
    logic [7:0]  repeat_rate_enable_r;
    logic [7:0]  simultaneous_touch_config_r;
    logic [7:0]  touch_pattern_config_r;
    logic [7:0]  touch_pattern_select_r;
    logic [2:0]  accepted_r;
    logic [2:0]  accepted_nxt;
    logic [1:0]  limit;
    logic [2:0]  qualify;
    logic [1:0]  qual_cnt;
    logic [1:0]  sel_cnt;
    logic        pattern_hit;
    logic [2:0]  effective;
    logic [2:0]  input_irq;
    logic        touch_irq;
    logic        unit_tick;
    logic [23:0] unit_cnt_r;
    logic        touch_block_enable;
    logic        pattern_detect_enable;

    ////////////////////////////////////////////////////////////////////////
    // Register writes.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            repeat_rate_enable_r        <= teq_pkg::REPEAT_RATE_ENABLE_RST;
            simultaneous_touch_config_r <= teq_pkg::SIMULTANEOUS_TOUCH_CONFIG_RST;
            touch_pattern_config_r      <= teq_pkg::TOUCH_PATTERN_CONFIG_RST;
            touch_pattern_select_r      <= teq_pkg::TOUCH_PATTERN_SELECT_RST;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == teq_pkg::REPEAT_RATE_ENABLE_ADDR)
                repeat_rate_enable_r <= {5'h00, reg_wdata_i[teq_pkg::INPUT_MASK_MSB:0]};
            else if (reg_addr_i == teq_pkg::SIMULTANEOUS_TOUCH_CONFIG_ADDR)
                simultaneous_touch_config_r <= {reg_wdata_i[teq_pkg::TOUCH_BLOCK_EN_BIT], 3'h0,
                    reg_wdata_i[teq_pkg::TOUCH_LIMIT_MSB:teq_pkg::TOUCH_LIMIT_LSB], 2'h0};
            else if (reg_addr_i == teq_pkg::TOUCH_PATTERN_CONFIG_ADDR)
                touch_pattern_config_r <= {reg_wdata_i[teq_pkg::PATTERN_EN_BIT], 3'h0,
                    reg_wdata_i[teq_pkg::PATTERN_THR_MSB:teq_pkg::PATTERN_ALERT_BIT]};
            else if (reg_addr_i == teq_pkg::TOUCH_PATTERN_SELECT_ADDR)
                touch_pattern_select_r <= {5'h00, reg_wdata_i[teq_pkg::INPUT_MASK_MSB:0]};
        end
    end

    // Register reads; unmapped offsets read as zero.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            reg_rdata_o <= 8'h00;
        else if (reg_rd_i)
        begin
            if (reg_addr_i == teq_pkg::REPEAT_RATE_ENABLE_ADDR)
                reg_rdata_o <= repeat_rate_enable_r;
            else if (reg_addr_i == teq_pkg::SIMULTANEOUS_TOUCH_CONFIG_ADDR)
                reg_rdata_o <= simultaneous_touch_config_r;
            else if (reg_addr_i == teq_pkg::TOUCH_PATTERN_CONFIG_ADDR)
                reg_rdata_o <= touch_pattern_config_r;
            else if (reg_addr_i == teq_pkg::TOUCH_PATTERN_SELECT_ADDR)
                reg_rdata_o <= touch_pattern_select_r;
            else
                reg_rdata_o <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Field decode.
    assign touch_block_enable    = simultaneous_touch_config_r[teq_pkg::TOUCH_BLOCK_EN_BIT];
    assign pattern_detect_enable = touch_pattern_config_r[teq_pkg::PATTERN_EN_BIT];

    // Simultaneous-touch limit: codes 10 and 11 both allow three.
    always_comb
    begin
        case (simultaneous_touch_config_r[teq_pkg::TOUCH_LIMIT_MSB:teq_pkg::TOUCH_LIMIT_LSB])
            2'h0:    limit = teq_pkg::LIMIT_ONE;
            2'h1:    limit = teq_pkg::LIMIT_TWO;
            default: limit = teq_pkg::LIMIT_FULL;
        endcase
    end

    // Scales one touch threshold by the pattern threshold code.
    function automatic logic [8:0] scale_thr(input logic [7:0] thr, input logic [1:0] code);
        logic [8:0] eighth;
        eighth = {4'h0, thr[7:3]};
        case (code)
            teq_pkg::PTHR_EIGHTH:        scale_thr = eighth;
            teq_pkg::PTHR_QUARTER:       scale_thr = {3'h0, thr[7:2]};
            teq_pkg::PTHR_THREE_EIGHTHS: scale_thr = eighth + {eighth[7:0], 1'b0};
            default:                     scale_thr = {1'b0, thr};
        endcase
    endfunction

    // Qualification of each input in the current polling cycle.
    always_comb
    begin
        qualify = 3'h0;
        for (int i = 0; i < 3; i++)
            qualify[i] = ({1'b0, delta_i[i*8 +: 8]} >
                          scale_thr(standby_i ? standby_thr_i[i*8 +: 8] : active_thr_i[i*8 +: 8],
                                    touch_pattern_config_r[teq_pkg::PATTERN_THR_MSB:teq_pkg::PATTERN_THR_LSB]))
                         | noise_i[i];
    end

    assign qual_cnt = 2'({1'b0, qualify[0]} + {1'b0, qualify[1]} + {1'b0, qualify[2]});
    assign sel_cnt  = 2'({1'b0, touch_pattern_select_r[0]} + {1'b0, touch_pattern_select_r[1]}
                         + {1'b0, touch_pattern_select_r[2]});

    // Pattern match by mode.
    assign pattern_hit = pattern_detect_enable &&
                         (touch_pattern_config_r[teq_pkg::PATTERN_COMPARE_BIT]
                          ? ((touch_pattern_select_r[2:0] & ~qualify) == 3'h0)
                          : (qual_cnt >= sel_cnt));

    // Pattern blocking follows the condition, judged each polling cycle.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pattern_block_o <= 1'b0;
        else if (poll_tick_i)
            pattern_block_o <= pattern_hit;
    end

    // Pattern flag: set wins, cleared only by host once the condition is gone.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            pattern_event_flag_o <= 1'b0;
        else if (poll_tick_i && pattern_hit)
            pattern_event_flag_o <= 1'b1;
        else if (int_clear_i && !pattern_block_o)
            pattern_event_flag_o <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Simultaneous-touch acceptance, filled in scan order up to the limit.
    always_comb
    begin
        logic [1:0] cnt;
        logic [2:0] base;
        cnt  = 2'h0;
        base = accepted_r & touch_det_i;
        if (!touch_block_enable)
            accepted_nxt = touch_det_i;
        else
        begin
            if ((accepted_r & ~touch_det_i) != 3'h0)
                base = 3'h0;
            accepted_nxt = base;
            for (int i = 0; i < 3; i++)
                cnt = cnt + {1'b0, base[i]};
            for (int i = 0; i < 3; i++)
            begin
                if (touch_det_i[i] && !base[i] && cnt < limit)
                begin
                    accepted_nxt[i] = 1'b1;
                    cnt             = cnt + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            accepted_r <= 3'h0;
        else if (poll_tick_i)
            accepted_r <= accepted_nxt;
    end

    // Many-touch flag: limit reached while others are blocked.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            many_touch_flag_o <= 1'b0;
        else if (poll_tick_i)
            many_touch_flag_o <= touch_block_enable && ((touch_det_i & ~accepted_nxt) != 3'h0);
    end

    // Inputs that count as touched after both kinds of blocking.
    assign effective = pattern_block_o ? 3'h0 : accepted_r;

    ////////////////////////////////////////////////////////////////////////
    // Time base for hold and repeat timing.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            unit_cnt_r <= 24'h000000;
        else if (unit_tick)
            unit_cnt_r <= 24'h000000;
        else
            unit_cnt_r <= unit_cnt_r + 24'h000001;
    end

    assign unit_tick = (unit_cnt_r == 24'(UNIT_CYCLES - 1));

    // Per-input press classification and repeat.
    for (genvar g = 0; g < 3; g++)
    begin : g_input
        teq_repeat_timer u_timer (
            .clk_i                (clk_i),
            .nrst_i               (nrst_i),
            .poll_tick_i          (poll_tick_i),
            .unit_tick_i          (unit_tick),
            .touched_i            (effective[g]),
            .repeat_en_i          (repeat_rate_enable_r[g]),
            .release_irq_enable_i (release_irq_enable_i[g]),
            .hold_code_i          (hold_time_code_i),
            .rate_code_i          (repeat_rate_code_i),
            .irq_o                (input_irq[g])
        );
    end

    assign touch_irq = (input_irq & irq_enable_i) != 3'h0;

    // Touch status: set on an accepted touch, host clear loses to a set.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            touch_status_o <= 3'h0;
        else
            touch_status_o <= (int_clear_i ? 3'h0 : touch_status_o)
                            | (poll_tick_i ? effective : 3'h0);
    end

    // Interrupt status drives the alert pin until the host clears it.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            int_status_o <= 1'b0;
        else if (touch_irq || (poll_tick_i && pattern_hit && !pattern_block_o
                 && touch_pattern_config_r[teq_pkg::PATTERN_ALERT_BIT]))
            int_status_o <= 1'b1;
        else if (int_clear_i)
            int_status_o <= 1'b0;
    end

    assign alert_n_o = ~int_status_o;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_pattern_seen;
        poll_tick_i && pattern_hit;
    endsequence

    // A pattern event that starts while nothing is blocked yet.
    sequence s_pattern_onset;
        poll_tick_i && pattern_hit && !pattern_block_o;
    endsequence

    a_pattern_blocks: assert property (s_pattern_seen |=> pattern_block_o && effective == 3'h0)
        else $error("pattern event did not block inputs");
    a_pattern_flag_set: assert property (s_pattern_seen |=> pattern_event_flag_o)
        else $error("pattern flag not set");
    a_pattern_flag_hold: assert property (pattern_event_flag_o && pattern_block_o
                                          |=> pattern_event_flag_o)
        else $error("pattern flag cleared while condition stood");
    a_pattern_release: assert property (poll_tick_i && !pattern_hit |=> !pattern_block_o)
        else $error("blocking outlived pattern condition");
    a_pattern_disabled: assert property (poll_tick_i && !pattern_detect_enable && !pattern_event_flag_o
                                         |=> !pattern_event_flag_o && !pattern_block_o)
        else $error("pattern hit while detection disabled");
    a_pattern_alert: assert property (s_pattern_onset ##0 touch_pattern_config_r[teq_pkg::PATTERN_ALERT_BIT]
                                      |=> int_status_o)
        else $error("pattern event raised no alert");
    a_flag_clear: assert property (int_clear_i && !pattern_block_o && !(poll_tick_i && pattern_hit)
                                   |=> !pattern_event_flag_o)
        else $error("pattern flag survived a clear");
    a_status_blocked: assert property (poll_tick_i && pattern_block_o && !int_clear_i
                                       |=> touch_status_o == $past(touch_status_o))
        else $error("blocked input set touch status");
    a_limit_kept: assert property (poll_tick_i && touch_block_enable && $countones(accepted_r) <= limit
                                   |=> $countones(accepted_r) <= limit)
        else $error("accepted inputs exceed the limit");
    a_limit_one: assert property (poll_tick_i && touch_block_enable && limit == teq_pkg::LIMIT_ONE
                                  |=> $countones(accepted_r) <= 1)
        else $error("more than one input accepted at limit one");
    a_no_block_off: assert property (poll_tick_i && !touch_block_enable
                                     |=> accepted_r == $past(touch_det_i))
        else $error("blocking acted while disabled");
    a_many_flag: assert property (poll_tick_i && touch_block_enable && (touch_det_i & ~accepted_nxt) != 3'h0
                                  |=> many_touch_flag_o)
        else $error("many-touch flag missing");
    a_alert_follow: assert property (int_status_o && !int_clear_i |=> int_status_o && !alert_n_o)
        else $error("alert pin not asserted with status");
    a_status_clear: assert property (int_clear_i && !touch_irq && !(poll_tick_i && pattern_hit)
                                     |=> !int_status_o && alert_n_o)
        else $error("alert pin not released by clear");
    a_irq_gated: assert property ((input_irq & irq_enable_i) != 3'h0 |=> int_status_o)
        else $error("enabled touch interrupt lost");
endmodule
`default_nettype wire

// *** teq_pkg.sv ***
`default_nettype none
package teq_pkg;
    // Register offsets.
    localparam logic [7:0] REPEAT_RATE_ENABLE_ADDR        = 8'h28;
    localparam logic [7:0] SIMULTANEOUS_TOUCH_CONFIG_ADDR = 8'h2A;
    localparam logic [7:0] TOUCH_PATTERN_CONFIG_ADDR      = 8'h2B;
    localparam logic [7:0] TOUCH_PATTERN_SELECT_ADDR      = 8'h2D;

    // Reset values.
    localparam logic [7:0] REPEAT_RATE_ENABLE_RST        = 8'h07;
    localparam logic [7:0] SIMULTANEOUS_TOUCH_CONFIG_RST = 8'h80;
    localparam logic [7:0] TOUCH_PATTERN_CONFIG_RST      = 8'h00;
    localparam logic [7:0] TOUCH_PATTERN_SELECT_RST      = 8'h07;

    // Field positions.
    localparam int INPUT_MASK_MSB       = 2;
    localparam int TOUCH_BLOCK_EN_BIT   = 7;
    localparam int TOUCH_LIMIT_MSB      = 3;
    localparam int TOUCH_LIMIT_LSB      = 2;
    localparam int PATTERN_EN_BIT       = 7;
    localparam int PATTERN_THR_MSB      = 3;
    localparam int PATTERN_THR_LSB      = 2;
    localparam int PATTERN_COMPARE_BIT  = 1;
    localparam int PATTERN_ALERT_BIT    = 0;

    // Simultaneous-touch limit decode.
    localparam logic [1:0] LIMIT_ONE  = 2'h1;
    localparam logic [1:0] LIMIT_TWO  = 2'h2;
    localparam logic [1:0] LIMIT_FULL = 2'h3;

    // Pattern threshold codes.
    localparam logic [1:0] PTHR_EIGHTH        = 2'h0;
    localparam logic [1:0] PTHR_QUARTER       = 2'h1;
    localparam logic [1:0] PTHR_THREE_EIGHTHS = 2'h2;

    // Timing: hold and repeat times step in 35 ms units.
    localparam int CLK_MHZ      = 250;
    localparam int TIME_UNIT_MS = 35;
    localparam int UNIT_CYCLES  = TIME_UNIT_MS * 1000 * CLK_MHZ;

    // Press classification states, Gray coded along the touch path.
    typedef enum logic [1:0] {
        TEQ_IDLE  = 2'h0,
        TEQ_SHORT = 2'h1,
        TEQ_HOLD  = 2'h3
    } teq_press_t;
endpackage
`default_nettype wire

// *** teq_repeat_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module teq_repeat_timer (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       poll_tick_i,
    input  wire logic       unit_tick_i,
    input  wire logic       touched_i,
    input  wire logic       repeat_en_i,
    input  wire logic       release_irq_enable_i,
    input  wire logic [3:0] hold_code_i,
    input  wire logic [3:0] rate_code_i,
    output logic            irq_o
);
    teq_pkg::teq_press_t state_r;
    logic                prev_r;
    logic [4:0]          hold_cnt_r;
    logic [4:0]          rate_cnt_r;
    logic                press;
    logic                release_ev;
    logic                hold_reached;
    logic                rate_reached;

    ////////////////////////////////////////////////////////////////////////
    // Edges are judged once per polling cycle.
    assign press        = poll_tick_i & touched_i & ~prev_r;
    assign release_ev   = poll_tick_i & ~touched_i & prev_r;
    assign hold_reached = unit_tick_i && (hold_cnt_r == ({1'b0, hold_code_i} + 5'h01));
    assign rate_reached = unit_tick_i && ((rate_cnt_r + 5'h01) == ({1'b0, rate_code_i} + 5'h01));

    // Touch level seen at the last polling cycle.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            prev_r <= 1'b0;
        else if (poll_tick_i)
            prev_r <= touched_i;
    end

    // Classifies short touch versus press-and-hold.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state_r    <= teq_pkg::TEQ_IDLE;
            hold_cnt_r <= 5'h00;
            rate_cnt_r <= 5'h00;
        end
        else if (release_ev)
            state_r <= teq_pkg::TEQ_IDLE;
        else if (press)
        begin
            state_r    <= teq_pkg::TEQ_SHORT;
            hold_cnt_r <= 5'h00;
        end
        else
        begin
            case (state_r)
                teq_pkg::TEQ_SHORT:
                begin
                    if (hold_reached && repeat_en_i)
                    begin
                        state_r    <= teq_pkg::TEQ_HOLD;
                        rate_cnt_r <= 5'h00;
                    end
                    else if (unit_tick_i && hold_cnt_r != 5'h1F)
                        hold_cnt_r <= hold_cnt_r + 5'h01;
                end
                teq_pkg::TEQ_HOLD:
                begin
                    if (rate_reached)
                        rate_cnt_r <= 5'h00;
                    else if (unit_tick_i)
                        rate_cnt_r <= rate_cnt_r + 5'h01;
                end
                default:
                    state_r <= teq_pkg::TEQ_IDLE;
            endcase
        end
    end

    // One pulse per interrupt cause.
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            irq_o <= 1'b0;
        else
            irq_o <= press
                   | (release_ev & ~repeat_en_i)
                   | (release_ev & (state_r == teq_pkg::TEQ_SHORT) & release_irq_enable_i)
                   | (~release_ev & ~press & (state_r == teq_pkg::TEQ_SHORT) & hold_reached
                      & repeat_en_i)
                   | (~release_ev & ~press & (state_r == teq_pkg::TEQ_HOLD) & rate_reached);
    end
endmodule
`default_nettype wire

// *** teq_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module teq_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output logic      [7:0] addr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o,
    output logic            clear_o
);
    // The bus idles with both strobes low.
    initial
    begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
        clear_o = 1'b0;
    end

    // One write; the caller enters just after an edge.
    // A quiet cycle follows so that back-to-back writes never retoggle the strobe at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clk_i);
        #1;
        wr_o = 1'b0;
        wdata_o = ~d;
        @(posedge clk_i);
        #1;
    endtask

    // One read; the data is taken a cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clk_i);
        #1;
        rd_o = 1'b0;
        @(posedge clk_i);
        #1;
        d = rdata_i;
    endtask

    // A one-cycle pulse on the clear line, then two quiet cycles.
    task automatic clear;
        clear_o = 1'b1;
        @(posedge clk_i);
        #1;
        clear_o = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// *** touch_event_qualifier_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module touch_event_qualifier_tb;
    logic clk, nrst, poll, stby, wr, rd, clr, many, pflag, pblk, ist, alert_n;
    logic [2:0] det, noise, tstat, irq_en, rel_en;
    logic [3:0] hold, rate;
    logic [7:0] addr, wdata, rdata, lim;
    logic [23:0] delta, athr, sthr;
    int miscompares;
    int comparisons;

    // Clock at 250 MHz.
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    teq_host_model host (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
                         .wdata_o(wdata), .clear_o(clr));

    teq_qualifier #(.UNIT_CYCLES(4)) dut (.clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .poll_tick_i(poll), .standby_i(stby),
        .touch_det_i(det), .noise_i(noise), .delta_i(delta), .active_thr_i(athr), .standby_thr_i(sthr),
        .irq_enable_i(irq_en), .release_irq_enable_i(rel_en), .hold_time_code_i(hold),
        .repeat_rate_code_i(rate), .int_clear_i(clr), .touch_status_o(tstat),
        .many_touch_flag_o(many), .pattern_event_flag_o(pflag), .pattern_block_o(pblk),
        .int_status_o(ist), .alert_n_o(alert_n));

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Two poll ticks, four cycles apart, then let the results settle.
    task automatic tick2;
        repeat (2)
        begin
            poll = 1'b1;
            @(posedge clk);
            #1;
            poll = 1'b0;
            repeat (3) @(posedge clk);
            #1;
        end
    endtask

    task automatic do_reset;
        nrst = 1'b0;
        det = 3'h0;
        noise = 3'h0;
        delta = 24'h0;
        irq_en = 3'h7;
        rel_en = 3'h7;
        hold = 4'h0;
        rate = 4'h0;
        repeat (8) @(posedge clk);
        #1;
        nrst = 1'b1;
    endtask

    task automatic t_regs;
        logic [7:0] d;
        host.rd(8'h28, d);
        check(d, 8'h07, "repeat enable reset");
        host.rd(8'h2A, d);
        check(d, 8'h80, "blocking config reset");
        host.rd(8'h2B, d);
        check(d, 8'h00, "pattern config reset");
        host.rd(8'h2D, d);
        check(d, 8'h07, "pattern select reset");
        host.rd(8'h29, d);
        check(d, 8'h00, "unmapped read");
        host.wr(8'h2B, 8'hFF);
        host.rd(8'h2B, d);
        check(d, 8'h8F, "pattern config fields");
    endtask

    task automatic t_block;
        do_reset();
        det = 3'h7;
        tick2();
        check(tstat, 3'h1, "one touch accepted");
        check(many, 1'b1, "many touch flag");
        det = 3'h6;
        tick2();
        check(tstat[2:1], 2'h1, "refill in scan order");
        for (int c = 0; c < 4; c++)
        begin
            do_reset();
            host.wr(8'h2A, (c == 0) ? 8'h00 : 8'h80 | 8'(c << 2));
            det = 3'h7;
            tick2();
            check(tstat, (c == 1) ? 3'h3 : 3'h7, "limit decode");
            check(many, c == 1, "many flag at limit");
        end
    endtask

    task automatic t_thresholds;
        for (int c = 0; c < 4; c++)
        begin
            do_reset();
            host.wr(8'h2B, 8'h80 | 8'(c << 2));
            host.wr(8'h2D, 8'h01);
            lim = (c == 3) ? 8'h40 : 8'(8 * (c + 1));
            delta = {16'h0, lim};
            tick2();
            check(pflag, 1'b0, "delta at threshold");
            delta = {16'h0, lim + 8'h01};
            tick2();
            check({pflag, pblk, ist}, 3'h6, "count pattern, no alert");
        end
        do_reset();
        host.wr(8'h2B, 8'h8C);
        host.wr(8'h2D, 8'h01);
        delta = 24'h000021;
        tick2();
        check(pflag, 1'b0, "active threshold in full");
        stby = 1'b1;
        tick2();
        check(pflag, 1'b1, "standby threshold in standby");
        stby = 1'b0;
    endtask

    task automatic t_pattern;
        do_reset();
        host.wr(8'h2D, 8'h05);
        host.wr(8'h2B, 8'h83);
        delta = 24'h000909;
        tick2();
        check(pflag, 1'b0, "wrong inputs in specific mode");
        noise = 3'h4;
        det = 3'h1;
        tick2();
        check({pflag, pblk, ist, alert_n}, 4'hE, "pattern event");
        check(tstat, 3'h0, "touch blocked by pattern");
        host.clear();
        check(pflag, 1'b1, "flag held while condition stays");
        noise = 3'h0;
        delta = 24'h0;
        det = 3'h0;
        tick2();
        check({pflag, pblk}, 2'h2, "blocking released");
        host.clear();
        check({pflag, alert_n}, 2'h1, "flag and alert cleared");
    endtask

    task automatic t_repeat;
        do_reset();
        rate = 4'h1;
        det = 3'h1;
        tick2();
        host.clear();
        repeat (6) tick2();
        check(ist, 1'b1, "repeat interrupt while held");
        host.clear();
        tick2();
        check(ist, 1'b1, "interrupt repeats at rate");
        do_reset();
        host.wr(8'h28, 8'h00);
        det = 3'h1;
        tick2();
        check({ist, alert_n}, 2'h2, "touch interrupt");
        host.clear();
        repeat (6) tick2();
        check(ist, 1'b0, "no repeat when off");
        det = 3'h0;
        tick2();
        check(ist, 1'b1, "release interrupt");
    endtask

    // Short touches with and without the release interrupt, then a masked input.
    task automatic t_release;
        for (int c = 0; c < 2; c++)
        begin
            do_reset();
            hold = 4'hF;
            rel_en = (c == 0) ? 3'h7 : 3'h6;
            det = 3'h1;
            tick2();
            check(ist, 1'b1, "short touch interrupt");
            host.clear();
            det = 3'h0;
            tick2();
            check(ist, c == 0, "short release interrupt");
        end
        do_reset();
        irq_en = 3'h6;
        det = 3'h1;
        tick2();
        check({tstat, ist}, 4'h2, "interrupt enable gates pin");
    endtask

    task automatic conclude;
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog cuts a hang short.
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end

    initial
    begin
        miscompares = 0;
        comparisons = 0;
        poll = 1'b0;
        stby = 1'b0;
        athr = {3{8'h40}};
        sthr = {3{8'h20}};
        do_reset();
        t_regs();
        t_block();
        t_thresholds();
        t_pattern();
        t_repeat();
        t_release();
        conclude();
    end
endmodule
`default_nettype wire
